// file: hdl/dither_pkg.sv
package dither_pkg;

    // frame layout of a 32-bit message
    localparam int          FRAME_W        = 32;
    localparam int          CHANNEL_SELECT_W         = 3;
    localparam int          NUM_CHANNEL_SELECT       = 8;
    localparam int          CODE_W         = 4;

    // message codes
    localparam logic [3:0]  CODE_CUR_DITH  = 4'h3;
    localparam logic [3:0]  CODE_DITH_PER  = 4'h4;
    localparam logic [3:0]  CODE_PEAK_RD   = 4'h5;

    // field positions inside the data part
    localparam int          HOLD_BIT       = 23;
    localparam int          STEP_LSB       = 11;
    localparam int          STEP_W         = 11;
    localparam int          SETP_LSB       = 0;
    localparam int          SETP_W         = 11;
    localparam int          NSTEP_W        = 5;
    localparam int          VALID_BIT      = 22;
    localparam int          MAX_LSB        = 11;
    localparam int          MIN_LSB        = 0;
    localparam int          PEAK_W         = 11;

    // reset values
    localparam logic [10:0] SETP_RST       = 11'h000;
    localparam logic [10:0] STEP_RST       = 11'h000;
    localparam logic [4:0]  NSTEP_RST      = 5'h00;
    localparam logic [10:0] MAX_RST        = 11'h000;
    localparam logic [10:0] MIN_RST        = 11'h7ff;

    // setpoint is pre-shifted so one step lsb is a quarter setpoint lsb
    localparam int          STEP_FRAC      = 2;
    // quarter-waves per dither period
    localparam int          QUARTERS       = 4;
    localparam int          PHASE_W        = 7;
    localparam int          TGT_W          = 21;

    // sum of M samples and the right shift giving the 11 reported msbs
    localparam int          SUM_W          = 19;
    localparam logic [1:0]  SAM_32         = 2'b00;
    localparam logic [1:0]  SAM_64         = 2'b01;
    localparam logic [1:0]  SAM_128        = 2'b10;
    localparam logic [1:0]  SAM_MAX        = 2'b11;
    localparam logic [4:0]  SHIFT_32       = 5'd4;
    localparam logic [4:0]  SHIFT_64       = 5'd5;
    localparam logic [4:0]  SHIFT_128      = 5'd6;
    // direct mode with 512 samples keeps two more fraction bits
    localparam logic [4:0]  SHIFT_512D     = 5'd6;

    // incoming message
    typedef struct packed {
        logic        write;
        logic [3:0]  code;
        logic [2:0]  channel_select;
        logic [23:0] data;
    } msg_frame_t;

endpackage

// file: hdl/dither_setup.sv
// Behaviour
// R1: current/dither answer: 0, code 0011, channel, hold, 0, step, setpoint.
// R2: enable low stops channel unless hold set; hold keeps dithering at setpoint.
// R3: step size lsb weighs a quarter of setpoint lsb.
// R4: zero step size or zero step count disables dithering.
// R5: hold, step size, setpoint and step count reset to zero.
// R6: setpoint is a fraction of full scale over 2 to the 11.
// R7: peak-to-peak dither is twice step times steps over 2 to the 13.
// R8: dither period message code 0100; bits 4:0 steps per quarter wave.
// R9: dither period lasts four times step count in pwm periods.
// R10: period answer: 0, code 0100, channel, zeros 23:5, steps in 4:0.
// R11: host sets bit 31, zero reads and one writes.
// R12: peak read code 0101; its channel also selects average readback.
// R13: valid bit 22 clears on read or channel change, sets on new data.
// R14: bits 21:11 give top 11 bits of largest period sum.
// R15: bits 10:0 give top 11 bits of smallest period sum.
// R16: before first dither cycle completes max reads 0, min 2047.
// R17: new data within two cycles on changed channel, else one.
// R18: direct mode 512 samples scales by 2 to 13; host checks overflow.
// R19: peak answer: 0, code 0101, channel, bit 23 zero.
// R20: sample code 11 means 512 direct, 128 current control.
// R21: capture min/max per dither cycle, transfer at each complete cycle end.
`timescale 1ns/1ps
module dither_setup
    import dither_pkg::*;
#(
    parameter int NCH = NUM_CHANNEL_SELECT
) (
    // clock and reset
    input  wire logic                      CORE_CLK,
    input  wire logic                      RST_N,
    // message port
    input  wire logic                      MSG_VALID,
    input  wire dither_pkg::msg_frame_t    MSG_DATA,
    output logic                           RESP_VALID,
    output logic [dither_pkg::FRAME_W-1:0] RESP_DATA,
    // control loop side
    input  wire logic                      ENABLE_IN,
    input  wire logic                      PWM_TICK,
    input  wire logic                      DIRECT_MODE,
    input  wire logic [1:0]                SAMPLE_SEL,
    input  wire logic                      SUM_VALID,
    input  wire logic [dither_pkg::CHANNEL_SELECT_W-1:0] SUM_CHANNEL_SELECT,
    input  wire logic [dither_pkg::SUM_W-1:0]  SUM_DATA,
    // per channel outputs
    output logic [NCH-1:0]                 CHANNEL_SELECT_RUN,
    output logic [NCH*dither_pkg::TGT_W-1:0] DITHER_TARGET,
    output logic [dither_pkg::CHANNEL_SELECT_W-1:0]  AVG_CHANNEL_SELECT_SEL
);
    import dither_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // per channel settings
    // plain flops per channel; eight short words are cheaper as registers
    // than as a memory that would need a read port per consumer
    logic [NCH-1:0]       hold_r;
    logic [STEP_W-1:0]    step_r  [NCH];
    logic [SETP_W-1:0]    setp_r  [NCH];
    logic [NSTEP_W-1:0]   nstep_r [NCH];
    logic [PHASE_W-1:0]   phase_r [NCH];
    // cycle end strobes are nets, each bit driven from its generate pass
    wire  [NCH-1:0]       cyc_end;

    // peak tracking state
    logic [CHANNEL_SELECT_W-1:0]    sel_r;
    logic                 arm_r;
    logic                 valid_r;
    logic [PEAK_W-1:0]    max_r, min_r;
    logic [PEAK_W-1:0]    trk_max_r, trk_min_r;
    logic                 resp_valid_r;
    logic [FRAME_W-1:0]   resp_r;

    ////////////////////////////////////////////////////////////////////////
    // message decode
    // the frame arrives whole, one word per MSG_VALID pulse; the serial
    // shifting lives outside this block, so a message is a single cycle
    // event here and back to back words are taken one per clock
    // write bit is ignored for the peak read, which is always a read
    wire                  is_cur   = MSG_VALID && MSG_DATA.code == CODE_CUR_DITH;
    wire                  is_per   = MSG_VALID && MSG_DATA.code == CODE_DITH_PER;
    wire                  is_peak  = MSG_VALID && MSG_DATA.code == CODE_PEAK_RD;
    // R11: write bit picks store versus read
    wire                  wr_cur   = is_cur && MSG_DATA.write;
    wire                  wr_per   = is_per && MSG_DATA.write;
    wire [CHANNEL_SELECT_W-1:0]     mch      = MSG_DATA.channel_select;
    wire                  channel_select_chg = is_peak && (mch != sel_r);

    ////////////////////////////////////////////////////////////////////////
    // settings storage, written by set messages
    // a read (write bit clear) leaves everything as it is and only answers;
    // the answer shows the values from before a write in the same edge
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            // R5: settings reset to zero
            hold_r <= '0;
            for (int i = 0; i < NCH; i++) begin
                step_r[i]  <= STEP_RST;
                setp_r[i]  <= SETP_RST;
                nstep_r[i] <= NSTEP_RST;
            end
        end else begin
            if (wr_cur) begin
                hold_r[mch] <= MSG_DATA.data[HOLD_BIT];
                step_r[mch] <= MSG_DATA.data[STEP_LSB +: STEP_W];
                setp_r[mch] <= MSG_DATA.data[SETP_LSB +: SETP_W];
            end
            // R8: steps per quarter wave
            if (wr_per) begin
                nstep_r[mch] <= MSG_DATA.data[NSTEP_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // dither generator, one per channel
    // phase counts pwm periods through one dither cycle of 4n periods;
    // the offset is a triangle in units of one step, so its extremes are
    // +n and -n and the peak to peak swing is 2*n*step quarter lsbs
    // limitation: a smaller step count written mid cycle ends that cycle
    // at once, which gives one period of uneven offset
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        wire [PHASE_W-1:0]       n1    = PHASE_W'(nstep_r[c]);
        // R9: period spans four quarters of n pwm periods
        wire [PHASE_W-1:0]       plen  = PHASE_W'(QUARTERS) * n1;
        // R4: either zero disables dither
        wire                     d_on  = (step_r[c] != '0) && (nstep_r[c] != '0);
        // R2: hold keeps the channel alive through enable loss
        wire                     run   = ENABLE_IN || hold_r[c];
        wire                     last  = !d_on || (phase_r[c] >= plen - PHASE_W'(1));
        logic signed [PHASE_W:0] off;
        // triangle: rise n, fall 2n, rise n back to zero
        always_comb begin
            if (!d_on) begin
                off = '0;
            end else if (phase_r[c] < n1) begin
                off = $signed({1'b0, phase_r[c]});
            end else if (phase_r[c] < PHASE_W'(3) * n1) begin
                off = $signed({1'b0, n1 + n1}) - $signed({1'b0, phase_r[c]});
            end else begin
                off = $signed({1'b0, phase_r[c]}) - $signed({1'b0, plen});
            end
        end
        // R3: step weighs a quarter setpoint lsb
        // R6: setpoint over 2^11, target over 2^13 of full scale
        wire signed [TGT_W-1:0]  base  = $signed(TGT_W'({setp_r[c], STEP_FRAC'(0)}));
        // R7: swing of +-n steps gives 2*step*n peak to peak
        wire signed [TGT_W-1:0]  swing = TGT_W'(off * $signed({1'b0, step_r[c]}));
        assign cyc_end[c] = PWM_TICK && run && last;

        // phase walks on pwm ticks; stopped channels restart at zero
        // restarting at zero means a resumed channel begins at its setpoint
        // and rises first, with no jump left over from before the stop
        always_ff @(posedge CORE_CLK) begin
            if (!RST_N) begin
                phase_r[c] <= '0;
            end else if (!run || !d_on) begin
                phase_r[c] <= '0;
            end else if (PWM_TICK) begin
                phase_r[c] <= last ? '0 : phase_r[c] + PHASE_W'(1);
            end
        end

        // R2: a stopped channel reports no run and zero target
        // run and target share one flop stage so they never disagree
        always_ff @(posedge CORE_CLK) begin
            if (!RST_N) begin
                CHANNEL_SELECT_RUN[c]                     <= 1'b0;
                DITHER_TARGET[c*TGT_W +: TGT_W] <= '0;
            end else begin
                CHANNEL_SELECT_RUN[c]                     <= run;
                DITHER_TARGET[c*TGT_W +: TGT_W] <= run ? base + swing : '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // period sum scaling to 11 reported bits
    // each window keeps the 11 top bits of the widest sum of 10-bit samples;
    // in direct mode with 512 samples the window sits two bits lower, so a
    // large sum wraps, which the host has to rule out itself
    logic [4:0]           shift;
    // R20: code 11 is 512 samples direct, 128 under current control
    // R18: 512 direct drops two fewer bits; overflow is the host's worry
    always_comb begin
        unique case (SAMPLE_SEL)
            SAM_32:  shift = SHIFT_32;
            SAM_64:  shift = SHIFT_64;
            SAM_128: shift = SHIFT_128;
            SAM_MAX: shift = DIRECT_MODE ? SHIFT_512D : SHIFT_128;
        endcase
    end
    wire [SUM_W-1:0]      sum_sh  = SUM_DATA >> shift;
    // R14: top bits of the period sum
    wire [PEAK_W-1:0]     sum_rep = sum_sh[PEAK_W-1:0];
    wire                  sum_hit = SUM_VALID && (SUM_CHANNEL_SELECT == sel_r);

    // tracker including a sum landing in the closing cycle
    // compares work on the 11 reported bits to keep the comparators small;
    // sums that differ only below them count as equal
    wire [PEAK_W-1:0]     cur_max = (sum_hit && sum_rep > trk_max_r) ? sum_rep : trk_max_r;
    wire [PEAK_W-1:0]     cur_min = (sum_hit && sum_rep < trk_min_r) ? sum_rep : trk_min_r;
    wire                  sel_end = cyc_end[sel_r] && !channel_select_chg;
    // R21: only a fully observed cycle is transferred
    wire                  xfer    = sel_end && arm_r;

    ////////////////////////////////////////////////////////////////////////
    // min/max capture for the selected channel
    // a channel change throws away a half-seen cycle: tracking restarts
    // disarmed and the first cycle end only arms, so a transfer always
    // covers one full dither cycle of the new channel
    // sums of other channels never touch the trackers
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            sel_r     <= '0;
            arm_r     <= 1'b0;
            trk_max_r <= MAX_RST;
            trk_min_r <= MIN_RST;
        end else if (channel_select_chg) begin
            // R17: new channel waits for a cycle start, so at most two cycles
            sel_r     <= mch;
            arm_r     <= 1'b0;
            trk_max_r <= MAX_RST;
            trk_min_r <= MIN_RST;
        end else if (sel_end) begin
            arm_r     <= 1'b1;
            trk_max_r <= MAX_RST;
            trk_min_r <= MIN_RST;
        end else begin
            trk_max_r <= cur_max;
            trk_min_r <= cur_min;
        end
    end

    // R16: reset values stand until the first transfer
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            max_r <= MAX_RST;
            min_r <= MIN_RST;
        end else if (xfer) begin
            // R15: smallest and largest of the finished cycle
            max_r <= cur_max;
            min_r <= cur_min;
        end
    end

    // R13: set wins over a read in the same cycle; channel change clears
    // a read landing with a transfer keeps the flag set, so a fresh set is
    // never lost behind a read that still carried the old one
    // the read that races the transfer shows the old values
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            valid_r <= 1'b0;
        end else if (xfer) begin
            valid_r <= 1'b1;
        end else if (is_peak) begin
            valid_r <= 1'b0;
        end
    end

    // R12: the peak read channel also drives the average readback
    // straight from the flop: the average path follows the new channel at once
    assign AVG_CHANNEL_SELECT_SEL = sel_r;

    ////////////////////////////////////////////////////////////////////////
    // response assembly
    // the answer is built from the state before this edge's update, so a
    // write reports what was stored and a changed channel reads invalid
    // unknown codes build nothing and leave the last word standing
    logic [FRAME_W-1:0]   resp_nxt;
    always_comb begin
        resp_nxt = '0;
        if (is_cur) begin
            // R1: stored settings of the addressed channel
            resp_nxt = {1'b0, CODE_CUR_DITH, mch, hold_r[mch], 1'b0,
                        step_r[mch], setp_r[mch]};
        end else if (is_per) begin
            // R10: zero padding then step count
            resp_nxt = {1'b0, CODE_DITH_PER, mch, 19'h00000, nstep_r[mch]};
        end else if (is_peak) begin
            // R19: header with bit 23 zero; changed channel reads invalid
            resp_nxt = {1'b0, CODE_PEAK_RD, mch, 1'b0, valid_r && !channel_select_chg,
                        max_r, min_r};
        end
    end

    // response registered; unknown codes give no answer
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            resp_valid_r <= 1'b0;
            resp_r       <= '0;
        end else begin
            resp_valid_r <= is_cur || is_per || is_peak;
            if (is_cur || is_per || is_peak) begin
                resp_r <= resp_nxt;
            end
        end
    end

    assign RESP_VALID = resp_valid_r;
    assign RESP_DATA  = resp_r;

endmodule // dither_setup

// file: tb/dither_setup_assertions.sv
`timescale 1ns/1ps
module dither_setup_assertions
    import dither_pkg::*;
#(
    parameter int NCH = NUM_CHANNEL_SELECT
) (
    // clock and reset
    input wire logic                           CORE_CLK,
    input wire logic                           RST_N,
    // message port
    input wire logic                           MSG_VALID,
    input wire dither_pkg::msg_frame_t         MSG_DATA,
    input wire logic                           RESP_VALID,
    input wire logic [dither_pkg::FRAME_W-1:0] RESP_DATA,
    // channel side
    input wire logic                           ENABLE_IN,
    input wire logic [NCH-1:0]                 CHANNEL_SELECT_RUN,
    input wire logic [dither_pkg::CHANNEL_SELECT_W-1:0]  AVG_CHANNEL_SELECT_SEL
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    // a message is only answered when its code is one we own
    wire logic [3:0] msg_code  = MSG_DATA.code;
    wire logic       msg_known = MSG_VALID && (msg_code inside {CODE_CUR_DITH, CODE_DITH_PER, CODE_PEAK_RD});
    sequence msg_then_resp(logic [3:0] c);
        msg_known && msg_code == c ##1 RESP_VALID;
    endsequence
    resp_head_a: assert property (msg_known |=> RESP_VALID && RESP_DATA[31:27] == {1'b0, $past(msg_code)})
        else $error("response header wrong");
    resp_refuse_a: assert property (!msg_known |=> !RESP_VALID)
        else $error("unexpected response");
    channel_select_echo_a: assert property (msg_then_resp(CODE_PEAK_RD) |-> RESP_DATA[26:24] == $past(MSG_DATA.channel_select))
        else $error("channel not echoed");
    period_zero_a: assert property (msg_then_resp(CODE_DITH_PER) |-> RESP_DATA[23:5] == 19'h00000)
        else $error("period answer padding");
    cur_zero_a: assert property (msg_then_resp(CODE_CUR_DITH) |-> !RESP_DATA[22])
        else $error("bit 22 set in setting answer");
    peak_zero_a: assert property (msg_then_resp(CODE_PEAK_RD) |-> !RESP_DATA[23])
        else $error("bit 23 set in peak answer");
    avg_sel_a: assert property (msg_known && msg_code == CODE_PEAK_RD |=> AVG_CHANNEL_SELECT_SEL == $past(MSG_DATA.channel_select))
        else $error("average channel not followed");
    resp_hold_a: assert property (!RESP_VALID |-> $stable(RESP_DATA))
        else $error("response word moved");
    run_enable_a: assert property (ENABLE_IN |=> CHANNEL_SELECT_RUN == {NCH{1'b1}})
        else $error("channel stopped while enabled");
endmodule // dither_setup_assertions

bind dither_setup dither_setup_assertions #(.NCH(NCH)) chk_u (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
    .MSG_VALID(MSG_VALID), .MSG_DATA(MSG_DATA), .RESP_VALID(RESP_VALID), .RESP_DATA(RESP_DATA),
    .ENABLE_IN(ENABLE_IN), .CHANNEL_SELECT_RUN(CHANNEL_SELECT_RUN), .AVG_CHANNEL_SELECT_SEL(AVG_CHANNEL_SELECT_SEL));

// file: tb/host_model.sv
`timescale 1ns/1ps
module host_model
    import dither_pkg::*;
(
    // clock
    input  wire logic                   core_clk,
    // message port
    output logic                        msg_valid,
    output dither_pkg::msg_frame_t      msg_data,
    input  wire logic                   resp_valid,
    input  wire logic [31:0]            resp_data
);
    // idle bus at time zero
    initial begin
        msg_valid = 1'b0;
        msg_data  = '0;
    end
    // write bit as given in the caller's frame
    // one word per message; the answer is picked up in the next cycle
    task automatic xfer(input msg_frame_t m, output logic got, output logic [31:0] r);
        @(negedge core_clk);
        msg_valid = 1'b1;
        msg_data  = m;
        @(negedge core_clk);
        msg_valid = 1'b0;
        msg_data  = ~m; // released lines never keep the old word
        got       = resp_valid;
        r         = resp_data;
    endtask
endmodule // host_model

// file: tb/dither_setup_tb.sv
`timescale 1ns/1ps
module dither_setup_tb;
    import dither_pkg::*;
    logic          core_clk = 1'b0, rst_n = 1'b0, enable_in = 1'b0, pwm_tick = 1'b0;
    logic          direct_mode = 1'b0, sum_valid = 1'b0, resp_valid, msg_valid, got;
    logic [1:0]    sample_sel = 2'h0;
    logic [2:0]    sum_channel_select = 3'h0, avg_sel;
    logic [18:0]   sum_data = 19'h00000;
    logic [31:0]   resp_data, r;
    logic [7:0]    channel_select_run;
    logic [167:0]  target;
    msg_frame_t    msg_data;
    int            error_cnt = 0, check_count = 0;
    logic [4:0]    shs [4] = '{SHIFT_32, SHIFT_64, SHIFT_128, SHIFT_512D};
    ////////////////////////////////////////
    always #4 core_clk = ~core_clk;
    dither_setup dut_u (.CORE_CLK(core_clk), .RST_N(rst_n), .MSG_VALID(msg_valid), .MSG_DATA(msg_data),
        .RESP_VALID(resp_valid), .RESP_DATA(resp_data), .ENABLE_IN(enable_in), .PWM_TICK(pwm_tick),
        .DIRECT_MODE(direct_mode), .SAMPLE_SEL(sample_sel), .SUM_VALID(sum_valid), .SUM_CHANNEL_SELECT(sum_channel_select),
        .SUM_DATA(sum_data), .CHANNEL_SELECT_RUN(channel_select_run), .DITHER_TARGET(target), .AVG_CHANNEL_SELECT_SEL(avg_sel));
    host_model host_u (.core_clk(core_clk), .msg_valid(msg_valid), .msg_data(msg_data),
        .resp_valid(resp_valid), .resp_data(resp_data));
    ////////////////////////////////////////
    // comparison and closing
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // bus helpers, all driven at the falling edge
    task automatic msg(input logic w, input logic [3:0] c, input logic [2:0] ch, input logic [23:0] d);
        host_u.xfer({w, c, ch, d}, got, r);
        check("resp_valid", got, 1);
    endtask
    task automatic tick();
        @(negedge core_clk) pwm_tick = 1'b1;
        @(negedge core_clk) pwm_tick = 1'b0;
    endtask
    task automatic sum(input logic [2:0] ch, input logic [18:0] v);
        @(negedge core_clk) {sum_valid, sum_channel_select, sum_data} = {1'b1, ch, v};
        @(negedge core_clk) {sum_valid, sum_data} = {1'b0, ~v};
    endtask
    ////////////////////////////////////////
    task automatic t_reset();
        msg(0, CODE_CUR_DITH, 0, 0);
        check("cur_rst", r, 32'h18000000);
        msg(0, CODE_DITH_PER, 0, 0);
        check("per_rst", r, 32'h20000000);
        msg(0, CODE_PEAK_RD, 0, 0);
        check("peak_rst", r, 32'h280007ff);
        $display("done reset values");
    endtask
    task automatic t_write();
        msg(1, CODE_CUR_DITH, 2, 24'h8aaaaa);
        check("cur_old", r, 32'h1a000000);
        msg(0, CODE_CUR_DITH, 2, 0);
        check("cur_new", r, 32'h1a8aaaaa);
        msg(1, CODE_DITH_PER, 2, 24'hffffff);
        msg(0, CODE_DITH_PER, 2, 0);
        check("per_new", r, 32'h2200001f);
        // unknown codes must stay silent
        for (int c = 0; c < 16; c++) begin
            if (!(c inside {3, 4, 5})) begin
                host_u.xfer({1'b1, 4'(c), 3'h0, 24'h0}, got, r);
                check("refused", got, 0);
            end
        end
        $display("done write and readback");
    endtask
    task automatic t_peak();
        logic [18:0] a;
        enable_in = 1'b1;
        msg(1, CODE_CUR_DITH, 1, 24'h000100);
        msg(0, CODE_PEAK_RD, 1, 0);
        check("peak_sel", r, 32'h290007ff);
        check("avg_sel", avg_sel, 1);
        check("flat_tgt", target[21+:21], 21'h400);
        tick();
        // one complete cycle per loop; foreign channel sum is ignored
        for (int s = 0; s < 4; s++) begin
            a = 19'h01230 + 19'(s) * 19'h01000;
            {sample_sel, direct_mode} = {2'(s), s == 3};
            // in-range sums; the extremes are neither first nor last
            sum(1, 19'h06000);
            sum(1, 19'h07ff0);
            sum(3, 19'h00001);
            sum(1, a);
            sum(1, 19'h05000);
            tick();
            msg(0, CODE_PEAK_RD, 1, 0);
            check("peak_head", r[31:22], {8'h29, 2'b01});
            check("peak_max", r[21:11], 11'(19'h07ff0 >> shs[s]));
            check("peak_min", r[10:0], 11'(a >> shs[s]));
        end
        msg(0, CODE_PEAK_RD, 1, 0);
        check("valid_clr", r[22], 0);
        $display("done peak tracking");
    endtask
    task automatic t_hold();
        @(negedge core_clk) enable_in = 1'b0;
        msg(1, CODE_CUR_DITH, 2, 24'h8002aa);
        msg(1, CODE_CUR_DITH, 2, 24'h8aaaaa);
        repeat (3) @(negedge core_clk);
        check("run", channel_select_run[2:1], 2'b10);
        check("stop_tgt", target[21+:21], 0);
        check("hold_tgt", target[42+:21], 21'h000aa8);
        tick();
        repeat (2) @(negedge core_clk);
        check("step_tgt", target[42+:21], 21'h000bfd);
        repeat (123) tick();
        repeat (2) @(negedge core_clk);
        check("period_tgt", target[42+:21], 21'h000aa8);
        $display("done hold on disable");
    endtask
    task automatic t_rerst();
        @(negedge core_clk) rst_n = 1'b0;
        repeat (3) @(negedge core_clk);
        check("rst_run", channel_select_run, 0);
        check("rst_tgt", target[42+:21], 0);
        rst_n = 1'b1;
        msg(0, CODE_CUR_DITH, 2, 0);
        check("cur_rerst", r, 32'h1a000000);
        msg(0, CODE_DITH_PER, 2, 0);
        check("per_rerst", r, 32'h22000000);
        msg(0, CODE_PEAK_RD, 0, 0);
        check("peak_rerst", r, 32'h280007ff);
        $display("done mid-run reset");
    endtask
    ////////////////////////////////////////
    // main sequence
    initial begin
        repeat (3) @(negedge core_clk);
        rst_n = 1'b1;
        t_reset();
        t_write();
        t_peak();
        t_hold();
        t_rerst();
        stop_test();
    end
    // watchdog well past the expected run length
    initial begin
        repeat (4000) @(posedge core_clk);
        error_cnt++;
        stop_test();
    end
endmodule // dither_setup_tb
